/* src/seq_pkg.sv */
// Constants, opcodes and status word layout of the microprogram sequencer.
// Summary of operation
// - Hold-select writes 10 to status 5:4
// - In hold mode line one repeats latched instruction
// - A 16, 8 or 12 bit select leaves hold mode unless line one repeats
// - Interrupt during idle leaves in-progress set
// - Download first jumps to data port address
// - Download steps on flag high, holds otherwise
// - Download ends only by interrupt or reset
// - Two extra addresses before underflow vector
// - Interrupts disabled after reset until enabled
// - Condition and index field decoding
// - Status bits 3 to 0 layout
// - Status bits 5:4 select offset width
// - Status bits 15:6 mask lines nine to zero
// - Conditional calls and jumps from data port
// - Indexed register jumps and counter forms
// - Indirect jump, skip by two, return
// - Subroutine stack opcodes
// - Narrow offsets are sign-extended before adding
// - Idle floats address port, holds counter
package seq_pkg;
  localparam int OP_W = 7;
  localparam int AW = 16;
  localparam int NUM_LINES = 10;
  localparam int NUM_CNT = 4;
  localparam int STACK_DEPTH = 16;
  localparam int VEC_DEPTH = 16;
  localparam int JREG_DEPTH = 4;
  localparam int HOLD_LINE = 1;
  localparam int SR_TRANSPARENT = 0;
  localparam int SR_SIGN = 1;
  localparam int SR_IRQ_OFF = 2;
  localparam int SR_LOCAL_SP = 3;
  localparam int SR_WIDTH_LO = 4;
  localparam int SR_WIDTH_HI = 5;
  localparam int SR_MASK_LO = 6;
  localparam int SR_MASK_HI = 15;
  localparam logic [15:0] SR_RESET = 16'h0004;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_HOLD = 2'h2;
  localparam logic [1:0] WIDTH_12 = 2'h3;
  localparam logic [1:0] CC_ALWAYS = 2'h0;
  localparam logic [1:0] CC_NOT_FLAG = 2'h1;
  localparam logic [1:0] CC_FLAG = 2'h2;
  localparam logic [1:0] CC_SIGN = 2'h3;
  localparam logic [6:0] OP_CONTINUE = 7'h00;
  localparam logic [6:0] OP_IDLE = 7'h10;
  localparam logic [6:0] OP_DOWNLOAD = 7'h20;
  localparam logic [6:0] OP_SEL16 = 7'h24;
  localparam logic [6:0] OP_HOLD_MODE = 7'h25;
  localparam logic [6:0] OP_SEL8 = 7'h26;
  localparam logic [6:0] OP_SEL12 = 7'h27;
  localparam logic [6:0] OP_CLEAR_ALL_IRQ = 7'h01;
  localparam logic [6:0] OP_CLEAR_CUR_IRQ = 7'h11;
  localparam logic [6:0] OP_RETURN_IRQ = 7'h03;
  localparam logic [6:0] OP_DISABLE_IRQ = 7'h16;
  localparam logic [6:0] OP_ENABLE_IRQ = 7'h36;
  localparam logic [6:0] OP_WRITE_STATUS = 7'h1C;
  localparam logic [6:0] OP_READ_STATUS = 7'h2E;
  localparam logic [6:0] OP_LOAD_VEC_PTR = 7'h1D;
  localparam logic [6:0] OP_WRITE_VEC = 7'h0D;
  localparam logic [6:0] OP_DEC_SP = 7'h02;
  localparam logic [6:0] OP_POP_TO_PORT = 7'h3E;
  localparam logic [6:0] OP_PUSH_FROM_PORT = 7'h1E;
  localparam logic [6:0] OP_READ_SP = 7'h2C;
  localparam logic [6:0] OP_WRITE_SP = 7'h0E;
  localparam logic [6:0] OP_PUSH_JREG = 7'h1F;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_DOWNLOAD = 1'b1
  } seq_state_type;
endpackage

/* src/seq_ctl_if.sv */
// Interface joining the sequencer core to its condition unit and subroutine stack.
`timescale 1ns/10ps
interface seq_ctl_if;
  logic [1:0] cc;
  logic flag;
  logic sign;
  logic [1:0] width;
  logic [15:0] data;
  logic [15:0] base;
  logic cond_ok;
  logic [15:0] rel_target;
  logic push;
  logic pop;
  logic dec;
  logic wr_ptr;
  logic sel_local;
  logic [15:0] push_data;
  logic [15:0] top;
  logic [3:0] ptr;
  modport cond_unit (input cc, flag, sign, width, data, base, output cond_ok, rel_target);
  modport stack_unit (input push, pop, dec, wr_ptr, sel_local, push_data, output top, ptr);
endinterface

/* src/seq_cond_unit.sv */
// Condition evaluation and relative jump target arithmetic.
`timescale 1ns/10ps
module seq_cond_unit (
  seq_ctl_if.cond_unit bus // Condition and offset operands
);
  import seq_pkg::*;

  function automatic logic [15:0] sext_offset(input logic [15:0] d, input logic [1:0] w);
    case (w)
      WIDTH_16: sext_offset = d;
      WIDTH_12: sext_offset = {{4{d[11]}}, d[11:0]};
      default: sext_offset = {{8{d[7]}}, d[7:0]};
    endcase
  endfunction

  always_comb begin
    case (bus.cc)
      CC_ALWAYS: bus.cond_ok = 1'b1;
      CC_NOT_FLAG: bus.cond_ok = ~bus.flag;
      CC_FLAG: bus.cond_ok = bus.flag;
      default: bus.cond_ok = bus.sign;
    endcase
  end

  // Hold mode shares the 8-bit width, so only code 11 and 00 differ from 8 bits.
  assign bus.rel_target = 16'(bus.base + sext_offset(bus.data, bus.width));
endmodule

/* src/seq_sub_stack.sv */
// Subroutine stack with separate global and local pointers.
`timescale 1ns/10ps
module seq_sub_stack (
  input wire logic mclk_in, // System clock
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire logic ce_in, // Clock enable
  seq_ctl_if.stack_unit bus // Stack requests
);
  import seq_pkg::*;

  logic [15:0] mem_r [STACK_DEPTH];
  logic [15:0] mem_nxt [STACK_DEPTH];
  logic [3:0] gsp_r, gsp_nxt, lsp_r, lsp_nxt, ptr, p;

  assign ptr = bus.sel_local ? lsp_r : gsp_r;
  assign bus.ptr = ptr;
  assign bus.top = mem_r[ptr];

  always_comb begin
    mem_nxt = mem_r;
    p = ptr;
    if (bus.push) begin
      p = 4'(ptr + 4'h1);
      mem_nxt[p] = bus.push_data;
    end else if (bus.pop || bus.dec) begin
      p = 4'(ptr - 4'h1);
    end else if (bus.wr_ptr) begin
      p = bus.push_data[3:0];
    end
    gsp_nxt = bus.sel_local ? gsp_r : p;
    lsp_nxt = bus.sel_local ? p : lsp_r;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        mem_r[i] <= 16'h0000;
      end
      gsp_r <= 4'h0;
      lsp_r <= 4'h0;
    end else if (ce_in) begin
      mem_r <= mem_nxt;
      gsp_r <= gsp_nxt;
      lsp_r <= lsp_nxt;
    end
  end
endmodule

/* src/microprogram_sequencer_control.sv */
// Microprogram sequencer core: decode, address generation, interrupts and download.
`timescale 1ns/10ps
module microprogram_sequencer_control (
  input wire logic mclk_in, // System clock, 25 MHz
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire logic ce_in, // Clock enable, freezes state when low
  input wire logic [seq_pkg::OP_W-1:0] instr_in, // Microinstruction opcode
  input wire logic [seq_pkg::AW-1:0] data_in, // Data port input
  input wire logic flag_in, // Flag condition input
  input wire logic [seq_pkg::NUM_LINES-1:1] irq_in, // Interrupt lines nine to one
  output logic [seq_pkg::AW-1:0] addr_out, // Microcode address
  output logic addr_oe_out, // Address port drive enable
  output logic [seq_pkg::AW-1:0] data_out, // Data port output
  output logic data_oe_out, // Data port drive enable
  output logic [15:0] status_out, // Sequencer status word
  output logic interrupt_in_progress_out // Interrupt in progress
);
  import seq_pkg::*;

  function automatic logic [3:0] top_line(input logic [NUM_LINES-1:0] v);
    top_line = 4'h0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (v[i]) begin
        top_line = 4'(i);
      end
    end
  endfunction

  seq_ctl_if ctl();
  seq_cond_unit u_cond (.bus(ctl.cond_unit));
  seq_sub_stack u_stack (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .bus(ctl.stack_unit));

  logic [15:0] addr_r, addr_nxt, data_r, data_nxt, sr_r, sr_nxt, push_data;
  logic addr_oe_r, addr_oe_nxt, data_oe_r, data_oe_nxt;
  logic [15:0] cnt_r [NUM_CNT];
  logic [15:0] cnt_nxt [NUM_CNT];
  logic [15:0] jreg_r [JREG_DEPTH];
  logic [15:0] jreg_nxt [JREG_DEPTH];
  logic [15:0] vec_r [VEC_DEPTH];
  logic [15:0] vec_nxt [VEC_DEPTH];
  logic [1:0] jreg_wp_r, jreg_wp_nxt;
  logic [3:0] vbase_r, vbase_nxt, vwp_r, vwp_nxt, line_r, line_nxt;
  logic [NUM_LINES-1:0] pend_r, pend_nxt, elig, clr, kept;
  logic interrupt_in_progress_r, interrupt_in_progress_nxt, take_r, take_nxt, hold_valid_r, hold_valid_nxt;
  logic [6:0] hold_instr_r, hold_instr_nxt, exec_op;
  seq_state_type state_r, state_nxt;
  logic [2:0] grp;
  logic [3:0] lo;
  logic [1:0] ii;
  logic hold_mode, dec_en, uf, push, pop, sdec, wptr;
  logic [1:0] dec_idx;

  assign hold_mode = (sr_r[SR_WIDTH_HI:SR_WIDTH_LO] == WIDTH_HOLD);
  assign grp = exec_op[6:4];
  assign lo = exec_op[3:0];
  assign ii = exec_op[1:0];

  assign ctl.cc = exec_op[3:2];
  assign ctl.flag = flag_in;
  assign ctl.sign = sr_r[SR_SIGN];
  assign ctl.width = sr_r[SR_WIDTH_HI:SR_WIDTH_LO];
  assign ctl.data = data_in;
  assign ctl.base = 16'(addr_r + 16'h0001);
  assign ctl.push = push;
  assign ctl.pop = pop;
  assign ctl.dec = sdec;
  assign ctl.wr_ptr = wptr;
  assign ctl.sel_local = sr_r[SR_LOCAL_SP];
  assign ctl.push_data = push_data;

  assign addr_out = addr_r;
  assign addr_oe_out = addr_oe_r;
  assign data_out = data_r;
  assign data_oe_out = data_oe_r;
  assign status_out = sr_r;
  assign interrupt_in_progress_out = interrupt_in_progress_r;

  ////////////////////////////////////////////////////////////////////////////////
  // The first cycle of a hold executes the port, later cycles the latched copy.
  always_comb begin
    exec_op = instr_in;
    hold_instr_nxt = hold_instr_r;
    hold_valid_nxt = 1'b0;
    if (hold_mode && irq_in[HOLD_LINE]) begin
      hold_valid_nxt = 1'b1;
      if (hold_valid_r) begin
        exec_op = hold_instr_r;
      end else begin
        hold_instr_nxt = instr_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    addr_nxt = 16'(addr_r + 16'h0001);
    addr_oe_nxt = 1'b1;
    data_nxt = data_r;
    data_oe_nxt = 1'b0;
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    jreg_nxt = jreg_r;
    jreg_wp_nxt = jreg_wp_r;
    vec_nxt = vec_r;
    vbase_nxt = vbase_r;
    vwp_nxt = vwp_r;
    interrupt_in_progress_nxt = interrupt_in_progress_r;
    take_nxt = 1'b0;
    line_nxt = line_r;
    state_nxt = state_r;
    clr = '0;
    dec_en = 1'b0;
    dec_idx = 2'h0;
    push = 1'b0;
    pop = 1'b0;
    sdec = 1'b0;
    wptr = 1'b0;
    push_data = 16'(addr_r + 16'h0001);
    uf = 1'b0;
    // Line one stops being an interrupt source while hold mode is selected.
    elig = pend_r & ~sr_r[SR_MASK_HI:SR_MASK_LO] & (hold_mode ? 10'h3FD : 10'h3FF);
    if (take_r) begin
      // The instruction on the port in the vector cycle is refetched after return.
      // A download ignores the port, so only an idle executed in run can swallow the vector.
      if (state_r == ST_RUN && exec_op == OP_IDLE) begin
        addr_nxt = addr_r;
        addr_oe_nxt = 1'b0;
      end else begin
        addr_nxt = vec_r[4'(vbase_r + line_r)];
        push = 1'b1;
        push_data = addr_r;
        state_nxt = ST_RUN;
      end
    end else begin
      // Recognition costs a cycle, so one more address goes out before the vector.
      if (!interrupt_in_progress_r && !sr_r[SR_IRQ_OFF] && (|elig)) begin
        take_nxt = 1'b1;
        interrupt_in_progress_nxt = 1'b1;
        line_nxt = top_line(elig);
      end
      if (state_r == ST_DOWNLOAD) begin
        if (flag_in) begin
          dec_en = 1'b1;
        end else begin
          addr_nxt = addr_r;
        end
      end else begin
        case (grp)
          3'b000: begin
            case (lo)
              4'h1: clr = '1;
              4'h2: sdec = 1'b1;
              4'h3: begin
                pop = 1'b1;
                addr_nxt = ctl.top;
                interrupt_in_progress_nxt = 1'b0;
              end
              4'hD: begin
                vec_nxt[vwp_r] = data_in;
                vwp_nxt = 4'(vwp_r + 4'h1);
              end
              4'hE: begin
                wptr = 1'b1;
                push_data = data_in;
              end
              default: ;
            endcase
          end
          3'b001: begin
            case (lo)
              4'h0: begin
                addr_nxt = addr_r;
                addr_oe_nxt = 1'b0;
              end
              4'h1: begin
                clr[line_r] = 1'b1;
                interrupt_in_progress_nxt = 1'b0;
              end
              4'h6: sr_nxt[SR_IRQ_OFF] = 1'b1;
              4'hC: sr_nxt = data_in;
              4'hD: begin
                vbase_nxt = data_in[3:0];
                vwp_nxt = data_in[3:0];
              end
              4'hE: begin
                push = 1'b1;
                push_data = data_in;
              end
              4'hF: begin
                jreg_nxt[jreg_wp_r] = data_in;
                jreg_wp_nxt = 2'(jreg_wp_r + 2'h1);
              end
              default: ;
            endcase
          end
          3'b010: begin
            case (lo)
              4'h0: begin
                addr_nxt = data_in;
                state_nxt = ST_DOWNLOAD;
              end
              4'h4: sr_nxt[SR_WIDTH_HI:SR_WIDTH_LO] = WIDTH_16;
              4'h5: sr_nxt[SR_WIDTH_HI:SR_WIDTH_LO] = WIDTH_HOLD;
              4'h6: sr_nxt[SR_WIDTH_HI:SR_WIDTH_LO] = WIDTH_8;
              4'h7: sr_nxt[SR_WIDTH_HI:SR_WIDTH_LO] = WIDTH_12;
              4'hC: begin
                data_nxt = {12'h000, ctl.ptr};
                data_oe_nxt = 1'b1;
              end
              4'hE: begin
                data_nxt = sr_r;
                data_oe_nxt = 1'b1;
              end
              default: ;
            endcase
          end
          3'b011: begin
            if (lo[3:2] == 2'b00) begin
              dec_en = 1'b1;
              dec_idx = ii;
            end else if (lo[3:2] == 2'b10) begin
              cnt_nxt[ii] = data_in;
            end else if (lo == 4'h6) begin
              sr_nxt[SR_IRQ_OFF] = 1'b0;
            end else if (lo == 4'hE) begin
              pop = 1'b1;
              data_nxt = ctl.top;
              data_oe_nxt = 1'b1;
            end
          end
          3'b100: begin
            if (ctl.cc == CC_SIGN) begin
              if (sr_r[SR_SIGN]) begin
                addr_nxt = data_in;
                sr_nxt[SR_SIGN] = 1'b0;
              end
            end else if (sr_r[SR_SIGN]) begin
              addr_nxt = jreg_r[ii];
            end else if (ctl.cond_ok) begin
              addr_nxt = data_in;
            end
          end
          3'b101: begin
            if (ctl.cond_ok) begin
              case (lo[1:0])
                2'b10: addr_nxt = jreg_r[data_in[1:0]];
                2'b01: addr_nxt = 16'(addr_r + 16'h0002);
                2'b11: begin
                  pop = 1'b1;
                  addr_nxt = ctl.top;
                end
                default: ;
              endcase
            end
          end
          3'b110: begin
            if (ctl.cc == CC_SIGN) begin
              dec_en = 1'b1;
              if (sr_r[SR_SIGN]) begin
                addr_nxt = jreg_r[ii];
              end
            end else if (ctl.cond_ok) begin
              addr_nxt = jreg_r[ii];
            end
          end
          default: begin
            if (ctl.cond_ok) begin
              case (lo[1:0])
                2'b00: begin
                  push = 1'b1;
                  addr_nxt = data_in;
                end
                2'b01: addr_nxt = ctl.rel_target;
                2'b10: begin
                  push = 1'b1;
                  addr_nxt = ctl.rel_target;
                end
                default: addr_nxt = data_in;
              endcase
            end
          end
        endcase
      end
      // Recognition must win over a clear or return decoded in the same cycle.
      if (take_nxt) begin
        interrupt_in_progress_nxt = 1'b1;
      end
    end
    if (dec_en) begin
      sr_nxt[SR_SIGN] = cnt_r[dec_idx][15];
      cnt_nxt[dec_idx] = 16'(cnt_r[dec_idx] - 16'h0001);
      // Flagged as counter zero reaches zero: with the recognition step the preload is
      // then two below the number of words a download delivers.
      uf = (dec_idx == 2'h0) && (cnt_r[0] == 16'h0001);
    end
    // A new request wins over a clear in the same cycle.
    kept = sr_r[SR_TRANSPARENT] ? (pend_r & ~clr & 10'h001) : (pend_r & ~clr);
    pend_nxt = kept | {irq_in, uf};
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_r <= ADDR_RESET;
      addr_oe_r <= 1'b1;
      data_r <= 16'h0000;
      data_oe_r <= 1'b0;
      sr_r <= SR_RESET;
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_r[i] <= 16'h0000;
        jreg_r[i] <= 16'h0000;
      end
      for (int i = 0; i < VEC_DEPTH; i++) begin
        vec_r[i] <= 16'h0000;
      end
      jreg_wp_r <= 2'h0;
      vbase_r <= 4'h0;
      vwp_r <= 4'h0;
      pend_r <= '0;
      interrupt_in_progress_r <= 1'b0;
      take_r <= 1'b0;
      line_r <= 4'h0;
      state_r <= ST_RUN;
      hold_instr_r <= OP_CONTINUE;
      hold_valid_r <= 1'b0;
    end else if (ce_in) begin
      addr_r <= addr_nxt;
      addr_oe_r <= addr_oe_nxt;
      data_r <= data_nxt;
      data_oe_r <= data_oe_nxt;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      jreg_r <= jreg_nxt;
      vec_r <= vec_nxt;
      jreg_wp_r <= jreg_wp_nxt;
      vbase_r <= vbase_nxt;
      vwp_r <= vwp_nxt;
      pend_r <= pend_nxt;
      interrupt_in_progress_r <= interrupt_in_progress_nxt;
      take_r <= take_nxt;
      line_r <= line_nxt;
      state_r <= state_nxt;
      hold_instr_r <= hold_instr_nxt;
      hold_valid_r <= hold_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_download_start;
    ce_in && !take_r && state_r == ST_RUN && exec_op == OP_DOWNLOAD;
  endsequence
  sequence s_download_step;
    ce_in && !take_r && state_r == ST_DOWNLOAD && flag_in;
  endsequence

  a_download_jump: assert property (s_download_start |=>
    addr_out == $past(data_in) && state_r == ST_DOWNLOAD) else $error("download jump wrong");
  a_download_step: assert property (s_download_step |=>
    addr_out == 16'($past(addr_out) + 16'h0001)) else $error("download step wrong");
  a_download_count: assert property (s_download_step |=>
    cnt_r[0] == 16'($past(cnt_r[0]) - 16'h0001)) else $error("counter zero not decremented");
  a_download_hold: assert property (ce_in && !take_r && state_r == ST_DOWNLOAD &&
    !flag_in |=> $stable(addr_out) && state_r == ST_DOWNLOAD)
    else $error("download did not hold");
  a_hold_select: assert property (ce_in && !take_r && state_r == ST_RUN &&
    exec_op == OP_HOLD_MODE |=> sr_r[SR_WIDTH_HI:SR_WIDTH_LO] == WIDTH_HOLD)
    else $error("hold mode not set");
  a_hold_repeat: assert property (ce_in && hold_mode && irq_in[HOLD_LINE] |=>
    !irq_in[HOLD_LINE] || !hold_mode || exec_op == $past(exec_op))
    else $error("held instruction not repeated");
  a_width_exit: assert property (ce_in && !take_r && state_r == ST_RUN &&
    exec_op == OP_SEL8 |=> sr_r[SR_WIDTH_HI:SR_WIDTH_LO] == WIDTH_8)
    else $error("width select failed");
  a_interrupt_in_progress_sticky: assert property (interrupt_in_progress_r && !(ce_in && !take_r &&
    (exec_op == OP_CLEAR_CUR_IRQ || exec_op == OP_RETURN_IRQ)) |=> interrupt_in_progress_r)
    else $error("in-progress flag dropped");
  a_irq_disabled: assert property (sr_r[SR_IRQ_OFF] && !take_r |=> !take_r)
    else $error("interrupt taken while disabled");
  a_idle_float: assert property (ce_in && !take_r && state_r == ST_RUN &&
    exec_op == OP_IDLE |=> !addr_oe_out && $stable(addr_out))
    else $error("idle did not float");
  a_idle_release: assert property (ce_in && !take_r && state_r == ST_RUN &&
    exec_op != OP_IDLE |=> addr_oe_out) else $error("address port not driven");
endmodule

/* tb/ucode_host_model.sv */
// Download host model that paces the control-store writer through the flag line.
`timescale 1ns/10ps
module ucode_host_model (
  input wire logic mclk_in, // System clock
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire logic stall_in, // High makes the writer stall every other cycle
  output logic flag_out // Word accepted, drives the sequencer flag input
);
  logic flag_nxt;
  // A slow writer drops the flag on alternate cycles, as a real one may.
  always_comb begin
    flag_nxt = stall_in ? ~flag_out : 1'b1;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= flag_nxt;
    end
  end
endmodule

/* tb/microprogram_sequencer_control_tb.sv */
// Self-checking testbench of the microprogram sequencer core.
`timescale 1ns/10ps
module microprogram_sequencer_control_tb;
  import seq_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic stall = 1'b0;
  logic flag_in;
  logic f;
  logic [6:0] instr_in = 7'h00;
  logic [15:0] data_in = 16'h0000;
  logic [15:0] p;
  logic [9:1] irq_in = 9'h000;
  logic [15:0] addr_out;
  logic [15:0] data_out;
  logic [15:0] status_out;
  logic addr_oe_out;
  logic data_oe_out;
  logic interrupt_in_progress_out;
  int err_total = 0;
  int comparisons = 0;
  microprogram_sequencer_control microprogram_sequencer_control_i (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .ce_in(ce_in), .instr_in(instr_in), .data_in(data_in),
    .flag_in(flag_in), .irq_in(irq_in), .addr_out(addr_out), .addr_oe_out(addr_oe_out),
    .data_out(data_out), .data_oe_out(data_oe_out), .status_out(status_out),
    .interrupt_in_progress_out(interrupt_in_progress_out));
  ucode_host_model ucode_host_model_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .stall_in(stall), .flag_out(flag_in));
  always #20 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Outputs are read 1 ns after the executing edge so their updates have landed.
  task automatic ex(input logic [6:0] op, input logic [15:0] d);
    instr_in <= op;
    data_in <= d;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    ck("rst_addr", 16'h0000, addr_out);
    ck("rst_status", 16'h0004, status_out);
    ck("rst_interrupt_in_progress", 16'h0000, {15'h0, interrupt_in_progress_out});
    irq_in[5] <= 1'b1;
    repeat (3) ex(OP_CONTINUE, 16'h0000);
    ck("no_irq_addr", 16'h0003, addr_out);
    ck("no_irq_interrupt_in_progress", 16'h0000, {15'h0, interrupt_in_progress_out});
    irq_in[5] <= 1'b0;
    ce_in <= 1'b0;
    ex(OP_CONTINUE, 16'h0000);
    ck("ce_hold", 16'h0003, addr_out);
    ce_in <= 1'b1;
  endtask
  task automatic t_jumps;
    logic tk;
    ex(OP_WRITE_STATUS, 16'h0006);
    ck("status_wr", 16'h0006, status_out);
    stall <= 1'b1;
    // Each condition runs twice so that both flag levels meet it.
    for (int c = 0; c < 8; c++) begin
      p = addr_out;
      f = flag_in;
      tk = (c / 2 == 0) || (c / 2 == 1 && !f) || (c / 2 == 2 && f) || (c / 2 == 3);
      ex({3'b111, 2'(c / 2), 2'b11}, 16'h0A00 + 16'(c));
      ck("jda", tk ? 16'h0A00 + 16'(c) : p + 16'h0001, addr_out);
    end
    stall <= 1'b0;
    ex(OP_SEL8, 16'h0000);
    ck("width8", {14'h0, WIDTH_8}, {14'h0, status_out[5:4]});
    p = addr_out;
    ex(7'h71, 16'hE3C0);
    ck("rel8", p + 16'h0001 + 16'hFFC0, addr_out);
  endtask
  task automatic t_stack;
    ex(OP_PUSH_FROM_PORT, 16'h1234);
    ex(OP_POP_TO_PORT, 16'h0000);
    ck("pop_data", 16'h1234, data_out);
    ck("pop_oe", 16'h0001, {15'h0, data_oe_out});
    ex(OP_CONTINUE, 16'h0000);
    ck("oe_pulse", 16'h0000, {15'h0, data_oe_out});
  endtask
  task automatic t_download;
    ex(7'h38, 16'h0006);
    ex(OP_LOAD_VEC_PTR, 16'h0000);
    ex(OP_WRITE_VEC, 16'h0300);
    ex(OP_CLEAR_ALL_IRQ, 16'h0000);
    ex(OP_ENABLE_IRQ, 16'h0000);
    stall <= 1'b1;
    ex(OP_DOWNLOAD, 16'h0100);
    ck("dl_jump", 16'h0100, addr_out);
    instr_in <= OP_IDLE;
    p = 16'h0100;
    for (int i = 0; i < 40 && addr_out !== 16'h0300; i++) begin
      if (i == 4) stall <= 1'b0;
      f = flag_in;
      @(posedge mclk_in);
      #1;
      if (addr_out !== 16'h0300) begin
        ck("dl_step", f ? p + 16'h0001 : p, addr_out);
        p = addr_out;
      end
    end
    ck("dl_last", 16'h0107, p);
    ck("dl_vector", 16'h0300, addr_out);
    ex(OP_CLEAR_CUR_IRQ, 16'h0000);
    ck("dl_interrupt_in_progress", 16'h0000, {15'h0, interrupt_in_progress_out});
    ex(OP_DEC_SP, 16'h0000);
  endtask
  task automatic t_hold;
    ex(OP_DISABLE_IRQ, 16'h0000);
    ex(OP_HOLD_MODE, 16'h0000);
    ck("hold_sel", {14'h0, WIDTH_HOLD}, {14'h0, status_out[5:4]});
    irq_in[1] <= 1'b1;
    ex(OP_IDLE, 16'h0000);
    repeat (3) ex(OP_CONTINUE, 16'h0000);
    ck("held_idle", 16'h0000, {15'h0, addr_oe_out});
    irq_in[1] <= 1'b0;
    ex(OP_SEL16, 16'h0000);
    ck("hold_exit", {14'h0, WIDTH_16}, {14'h0, status_out[5:4]});
    ck("oe_back", 16'h0001, {15'h0, addr_oe_out});
    ex(OP_CLEAR_ALL_IRQ, 16'h0000);
  endtask
  // Deliberately leaves interrupts on during a held idle to see the stuck flag.
  task automatic t_idle_irq;
    ex(OP_ENABLE_IRQ, 16'h0000);
    ex(OP_HOLD_MODE, 16'h0000);
    irq_in[1] <= 1'b1;
    irq_in[3] <= 1'b1;
    ex(OP_IDLE, 16'h0000);
    repeat (3) ex(OP_CONTINUE, 16'h0000);
    ck("idle_interrupt_in_progress", 16'h0001, {15'h0, interrupt_in_progress_out});
    ck("idle_oe", 16'h0000, {15'h0, addr_oe_out});
    irq_in <= 9'h000;
    ex(OP_SEL16, 16'h0000);
    irq_in[5] <= 1'b1;
    p = addr_out;
    repeat (2) ex(OP_CONTINUE, 16'h0000);
    ck("blocked", p + 16'h0002, addr_out);
    ck("still_interrupt_in_progress", 16'h0001, {15'h0, interrupt_in_progress_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #1;
    t_reset();
    t_jumps();
    t_stack();
    t_download();
    t_hold();
    t_idle_irq();
    end_of_test();
  end
  // The whole run needs about 60 cycles; this allows ample margin.
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_total++;
    end_of_test();
  end
endmodule
